// ---- pkg/cpif_pkg.sv ----
package cpif_pkg;

   // ==========================================================
   // operation word fields
   localparam logic [3:0] LINEF_CODE = 4'hf;
   localparam int         LINE_LSB   = 12;
   localparam int         LINE_W     = 4;
   localparam int         SEL_LSB    = 9;
   localparam int         SEL_W      = 3;
   localparam int         TYPE_LSB   = 6;
   localparam int         TYPE_W     = 3;

   // ==========================================================
   // cpu space encoding of a coprocessor access
   localparam logic [2:0] FC_CPU_SPACE    = 3'h7;
   localparam logic [3:0] CPU_TYPE_COPROC = 4'h2;
   localparam int         CT_LSB          = 16;
   localparam int         SEL_ADDR_LSB    = 13;
   localparam int         REG_W           = 5;
   localparam logic [2:0] SEL_NONE        = 3'h0;

   // ==========================================================
   // interface register byte offsets (a4..a0)
   localparam logic [4:0] OFS_RESPONSE  = 5'h00;
   localparam logic [4:0] OFS_CONTROL   = 5'h02;
   localparam logic [4:0] OFS_SAVE      = 5'h04;
   localparam logic [4:0] OFS_RESTORE   = 5'h06;
   localparam logic [4:0] OFS_OPWORD    = 5'h08;
   localparam logic [4:0] OFS_COMMAND   = 5'h0a;
   localparam logic [4:0] OFS_CONDITION = 5'h0e;
   localparam logic [4:0] OFS_OPERAND   = 5'h10;
   localparam logic [4:0] OFS_REGSEL    = 5'h14;
   localparam logic [4:0] OFS_INSTR_PTR = 5'h18;
   localparam logic [4:0] OFS_OPND_PTR  = 5'h1c;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0]  fc;
      logic        rd;     // 1 read, 0 write
      logic        word;   // 16-bit access, data in low half
      logic [31:0] wdata;
   } cpif_bus_t;

   typedef struct packed {
      logic [31:0] ea;
      logic [2:0]  space;
      logic        to_cop; // 1 memory to coprocessor
      logic [4:0]  interface_register;
   } cpif_xfer_t;

   localparam cpif_bus_t BUS_IDLE = '0;

endpackage : cpif_pkg

// ---- core/cpif_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module cpif_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   // ==========================================================
   // two stages; the first is read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule : cpif_sync

`default_nettype wire

// ---- core/cpif_engine.sv ----
// Overview of operation
// - only words with top four bits all ones are coprocessor candidates
// - selector comes from bits 11..9 of the first word
// - a line-f word with selector zero is no coprocessor instruction
// - selector zero with nonzero type raises unimplemented, no dialogue
// - no selector-zero interface cycle except via alternate space move
// - interface registers reached only in cpu space function code
// - cycle type 0010 on address 19..16 during coprocessor access
// - selector copied onto address 15..13 on every interface register access except the alternate space move
// - seven coprocessors (selectors 1 to 7) told apart by the three selector lines
// - address 31..20 and 12..5 are zero during access
// - address 4..0 pick the interface register
// - result to memory: read interface register, then write memory
// - operand to coprocessor: read memory, then write interface register
// - accesses are ordinary asynchronous cycles closed by handshake
// - after writing the command, read the response register
`timescale 1ns/10ps
`default_nettype none

module cpif_engine (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 op_valid_i,
   input  wire logic [15:0]          op_word_i,
   input  wire logic [15:0]          cmd_word_i,
   input  wire logic                 resp_req_i,
   input  wire logic                 xfer_valid_i,
   input  wire cpif_pkg::cpif_xfer_t xfer_i,
   input  wire logic                 alt_valid_i,
   input  wire cpif_pkg::cpif_bus_t  alt_i,
   input  wire logic                 bus_ack_i,
   input  wire logic [31:0]          bus_rdata_i,
   output logic                      bus_req_o,
   output cpif_pkg::cpif_bus_t       bus_o,
   output logic                      busy_o,
   output logic                      resp_valid_o,
   output logic [15:0]               resp_word_o,
   output logic                      unimpl_o,
   output logic                      linef_o,
   output logic                      xfer_done_o,
   output logic [31:0]               xfer_data_o
);
   import cpif_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD_WR,
      ST_RESP_RD,
      ST_MEM_RD,
      ST_CIR_WR,
      ST_CIR_RD,
      ST_MEM_WR,
      ST_ALT
   } cpif_state_t;

   cpif_state_t       state_r;
   cpif_state_t       state_nxt;
   logic [SEL_W-1:0]  sel_r;
   cpif_xfer_t        xfer_r;
   logic [31:0]       data_r;
   cpif_bus_t         bus_r;
   cpif_bus_t         bus_nxt;
   logic              bus_req_r;
   logic              cyc_busy_r;
   logic              start_nxt;
   logic              ack_s;
   logic              cyc_done;
   logic              op_take;
   logic [SEL_W-1:0]  op_sel;
   logic [TYPE_W-1:0] op_type;

   // ==========================================================
   // helpers

   // line-f test on the first instruction word
   function automatic logic is_linef(input logic [15:0] w);
      return w[LINE_LSB +: LINE_W] == LINEF_CODE;
   endfunction : is_linef

   // cpu space cycle to one interface register of one coprocessor
   function automatic cpif_bus_t cir_cycle(input logic [SEL_W-1:0] sel,
                                           input logic [REG_W-1:0] ofs,
                                           input logic             rd,
                                           input logic             word,
                                           input logic [31:0]      wd);
      cpif_bus_t c;
      c       = BUS_IDLE;
      c.fc    = FC_CPU_SPACE;
      c.addr[CT_LSB +: 4] = CPU_TYPE_COPROC;
      c.addr[SEL_ADDR_LSB +: SEL_W] = sel;
      // register select lines; rest stay zero
      c.addr[REG_W-1:0] = ofs;
      c.rd    = rd;
      c.word  = word;
      c.wdata = wd;
      return c;
   endfunction : cir_cycle

   // ==========================================================
   // handshake input synchroniser; read data is only sampled
   // once the acknowledge is seen, so it is held stable by then
   cpif_sync #(
      .WIDTH (1)
   ) u_ack_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (bus_ack_i),
      .sync_o  (ack_s)
   );

   // ==========================================================
   // operation word decode
   assign op_sel   = op_word_i[SEL_LSB +: SEL_W];
   assign op_type  = op_word_i[TYPE_LSB +: TYPE_W];
   assign op_take  = (state_r == ST_IDLE) && op_valid_i &&
                     is_linef(op_word_i) && (op_sel != SEL_NONE);
   // a cycle is over once strobe and acknowledge are both back low
   assign cyc_done = cyc_busy_r && !bus_req_r && !ack_s;

   // ==========================================================
   // sequencing of bus cycles
   always_comb begin
      state_nxt = state_r;
      bus_nxt   = bus_r;
      start_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (op_take) begin
               state_nxt = ST_CMD_WR;
               start_nxt = 1'b1;
               bus_nxt   = cir_cycle(op_sel, OFS_COMMAND, 1'b0, 1'b1,
                                     {16'h0, cmd_word_i});
            end else if (op_valid_i) begin
               state_nxt = ST_IDLE;
            end else if (resp_req_i && sel_r != SEL_NONE) begin
               state_nxt = ST_RESP_RD;
               start_nxt = 1'b1;
               bus_nxt   = cir_cycle(sel_r, OFS_RESPONSE, 1'b1, 1'b1,
                                     32'h0);
            end else if (xfer_valid_i && sel_r != SEL_NONE) begin
               start_nxt = 1'b1;
               if (xfer_i.to_cop) begin
                  state_nxt  = ST_MEM_RD;
                  bus_nxt    = BUS_IDLE;
                  bus_nxt.addr  = xfer_i.ea;
                  bus_nxt.fc    = xfer_i.space;
                  bus_nxt.rd    = 1'b1;
               end else begin
                  state_nxt = ST_CIR_RD;
                  bus_nxt   = cir_cycle(sel_r, xfer_i.interface_register, 1'b1, 1'b0,
                                        32'h0);
               end
            end else if (alt_valid_i) begin
               // the only path to a selector-zero access
               state_nxt = ST_ALT;
               start_nxt = 1'b1;
               bus_nxt   = alt_i;
            end
         end
         ST_CMD_WR: begin
            if (cyc_done) begin
               state_nxt = ST_RESP_RD;
               start_nxt = 1'b1;
               bus_nxt   = cir_cycle(sel_r, OFS_RESPONSE, 1'b1, 1'b1,
                                     32'h0);
            end
         end
         ST_MEM_RD: begin
            if (cyc_done) begin
               state_nxt = ST_CIR_WR;
               start_nxt = 1'b1;
               bus_nxt   = cir_cycle(sel_r, xfer_r.interface_register, 1'b0, 1'b0,
                                     data_r);
            end
         end
         ST_CIR_RD: begin
            if (cyc_done) begin
               state_nxt     = ST_MEM_WR;
               start_nxt     = 1'b1;
               bus_nxt       = BUS_IDLE;
               bus_nxt.addr  = xfer_r.ea;
               bus_nxt.fc    = xfer_r.space;
               bus_nxt.wdata = data_r;
            end
         end
         ST_RESP_RD, ST_CIR_WR, ST_MEM_WR, ST_ALT: begin
            if (cyc_done) begin
               state_nxt = ST_IDLE;
               bus_nxt   = BUS_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            bus_nxt   = BUS_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state and cycle descriptor
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         bus_r   <= BUS_IDLE;
      end else begin
         state_r <= state_nxt;
         bus_r   <= bus_nxt;
      end
   end

   // ==========================================================
   // selector and transfer request capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_r  <= SEL_NONE;
         xfer_r <= '0;
      end else begin
         // selector kept for the whole dialogue
         if (op_take) begin
            sel_r <= op_sel;
         end
         if (state_r == ST_IDLE && xfer_valid_i) begin
            xfer_r <= xfer_i;
         end
      end
   end

   // ==========================================================
   // asynchronous strobe: raise, hold to acknowledge, drop,
   // then wait for the acknowledge to fall before the next one
   // full four-phase handshake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_req_r  <= 1'b0;
         cyc_busy_r <= 1'b0;
      end else if (start_nxt) begin
         bus_req_r  <= 1'b1;
         cyc_busy_r <= 1'b1;
      end else if (bus_req_r && ack_s) begin
         bus_req_r  <= 1'b0;
      end else if (cyc_done) begin
         cyc_busy_r <= 1'b0;
      end
   end

   // ==========================================================
   // read data latch at the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_r <= 32'h0;
      end else if (bus_req_r && ack_s && bus_r.rd) begin
         data_r <= bus_rdata_i;
      end
   end

   // ==========================================================
   // result flags toward the core, one-cycle pulses; response word and transfer data held until next update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resp_valid_o <= 1'b0;
         resp_word_o  <= 16'h0;
         unimpl_o     <= 1'b0;
         linef_o      <= 1'b0;
         xfer_done_o  <= 1'b0;
         xfer_data_o  <= 32'h0;
      end else begin
         resp_valid_o <= (state_r == ST_RESP_RD) && cyc_done;
         if ((state_r == ST_RESP_RD) && cyc_done) begin
            resp_word_o <= data_r[15:0];
         end
         // unimplemented path, no bus cycle started
         unimpl_o <= (state_r == ST_IDLE) && op_valid_i &&
                     is_linef(op_word_i) && (op_sel == SEL_NONE) &&
                     (op_type != '0);
         // plain line-f trap when type is also zero
         linef_o  <= (state_r == ST_IDLE) && op_valid_i &&
                     is_linef(op_word_i) && (op_sel == SEL_NONE) &&
                     (op_type == '0);
         xfer_done_o <= cyc_done && (state_r == ST_CIR_WR ||
                        state_r == ST_MEM_WR || state_r == ST_ALT);
         if (cyc_done) begin
            xfer_data_o <= data_r;
         end
      end
   end

   // ==========================================================
   // outputs straight from flops
   assign bus_req_o = bus_req_r;
   assign bus_o     = bus_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (state_nxt != ST_IDLE);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic cir_state;
   assign cir_state = (state_r == ST_CMD_WR) || (state_r == ST_RESP_RD) ||
                      (state_r == ST_CIR_WR) || (state_r == ST_CIR_RD);

   sequence seq_cmd_done;
      (state_r == ST_CMD_WR) && cyc_done;
   endsequence
   sequence seq_resp_issue;
      (state_r == ST_RESP_RD) && bus_r.rd &&
      (bus_r.addr[REG_W-1:0] == OFS_RESPONSE) ##1 bus_req_r;
   endsequence
   sequence seq_accept;
      (state_r == ST_IDLE) ##1 (state_r == ST_CMD_WR);
   endsequence

   cpu_space_fc_a: assert property (
      bus_req_r && cir_state |-> bus_r.fc == FC_CPU_SPACE)
      else $error("interface access outside cpu space");
   cycle_type_a: assert property (
      bus_req_r && cir_state |-> bus_r.addr[19:16] == CPU_TYPE_COPROC)
      else $error("wrong cpu space cycle type");
   sel_copy_a: assert property (
      bus_req_r && cir_state |-> bus_r.addr[15:13] == sel_r &&
                                 sel_r != SEL_NONE)
      else $error("selector not on address lines");
   zero_lines_a: assert property (
      bus_req_r && cir_state |-> bus_r.addr[31:20] == 12'h0 &&
                                 bus_r.addr[12:5] == 8'h0)
      else $error("unused address lines not zero");
   no_sel_zero_a: assert property (
      bus_req_r && bus_r.fc == FC_CPU_SPACE &&
      bus_r.addr[19:16] == CPU_TYPE_COPROC &&
      bus_r.addr[15:13] == SEL_NONE |-> state_r == ST_ALT)
      else $error("selector zero cycle not from alternate move");
   resp_after_cmd_a: assert property (
      seq_cmd_done |=> seq_resp_issue)
      else $error("response not read after command");
   linef_gate_a: assert property (
      seq_accept |-> $past(op_word_i[15:12]) == LINEF_CODE)
      else $error("dialogue started on non line-f word");
   sel_take_a: assert property (
      seq_accept |-> sel_r == $past(op_word_i[11:9]))
      else $error("selector not taken from bits 11..9");
   unimpl_path_a: assert property (
      state_r == ST_IDLE && op_valid_i && is_linef(op_word_i) &&
      op_sel == SEL_NONE && op_type != '0 |=>
      unimpl_o && state_r == ST_IDLE && !bus_req_r)
      else $error("unimplemented path not taken");
   opnd_in_a: assert property (
      state_r == ST_MEM_RD && cyc_done |=> state_r == ST_CIR_WR &&
      !bus_r.rd && bus_r.wdata == $past(data_r) &&
      bus_r.addr[4:0] == xfer_r.interface_register ##1 bus_req_r)
      else $error("operand not written to register after read");
   result_out_a: assert property (
      state_r == ST_CIR_RD && cyc_done |=> state_r == ST_MEM_WR &&
      !bus_r.rd && bus_r.wdata == $past(data_r) &&
      bus_r.addr == xfer_r.ea && bus_r.fc == xfer_r.space)
      else $error("result not written to memory after read");
   handshake_a: assert property (
      $fell(bus_req_r) |-> $past(ack_s) ##1 !bus_req_r)
      else $error("strobe dropped without acknowledge");

endmodule : cpif_engine

`default_nettype wire

// ---- tb/cpif_cop_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module cpif_cop_model #(
   parameter logic [15:0] RESP_BASE = 16'h8000
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                bus_req_i,
   input  wire cpif_pkg::cpif_bus_t bus_i,
   output var  logic                bus_ack_o,
   output var  logic [31:0]         bus_rdata_o
);
   import cpif_pkg::*;

   logic [31:0] mem_r [16];
   logic [31:0] cir_r [8];
   logic [1:0]  wait_r;
   logic        armed_r;
   logic        cop_hit;
   logic [31:0] rd_val;
   integer      seed;

   // ==========================================================
   // memory image, random so a stuck data path shows
   initial begin
      seed = 32'h3e48;
      for (int i = 0; i < 16; i++) begin
         mem_r[i] = $random(seed);
      end
   end

   // select from space code and address 19..16
   assign cop_hit = bus_i.fc == FC_CPU_SPACE &&
                    bus_i.addr[19:16] == CPU_TYPE_COPROC;

   // one register set shared by all selectors, a4..a0 pick
   always_comb begin
      rd_val = mem_r[bus_i.addr[5:2]];
      if (cop_hit) begin
         case (bus_i.addr[4:0])
            OFS_RESPONSE:
               rd_val = {16'h0, RESP_BASE | {13'h0, bus_i.addr[15:13]}};
            OFS_OPERAND, OFS_INSTR_PTR, OFS_OPND_PTR:
               rd_val = cir_r[bus_i.addr[4:2]];
            default: rd_val = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // four-phase slave handshake, random delay
   // slave-only unit: never masters, the engine moves all data
   always @(posedge clk_i) begin
      if (rst_i) begin
         bus_ack_o   <= 1'b0;
         bus_rdata_o <= 32'h0;
         armed_r     <= 1'b0;
         wait_r      <= 2'h0;
      end else if (bus_ack_o) begin
         if (!bus_req_i) begin
            bus_ack_o   <= 1'b0;
            bus_rdata_o <= ~bus_rdata_o;  // released: no stale data
            armed_r     <= 1'b0;
         end
      end else if (bus_req_i && !armed_r) begin
         armed_r <= 1'b1;
         wait_r  <= 2'($random(seed));
      end else if (armed_r && wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else if (armed_r) begin
         bus_ack_o   <= 1'b1;
         bus_rdata_o <= rd_val;
         if (!bus_i.rd && !cop_hit) begin
            mem_r[bus_i.addr[5:2]] <= bus_i.wdata;
         end else if (!bus_i.rd && bus_i.addr[4:0] inside
                      {OFS_OPERAND, OFS_INSTR_PTR, OFS_OPND_PTR}) begin
            cir_r[bus_i.addr[4:2]] <= bus_i.wdata;
         end
      end
   end

endmodule : cpif_cop_model

`default_nettype wire

// ---- tb/tb_coprocessor_interface_addressing.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_coprocessor_interface_addressing;
   import cpif_pkg::*;

   logic        clk_i, rst_i, op_valid_i, resp_req_i, xfer_valid_i;
   logic        alt_valid_i, bus_ack_i, bus_req_o, busy_o, resp_valid_o;
   logic        unimpl_o, linef_o, xfer_done_o, req_q;
   logic [15:0] op_word_i, cmd_word_i, resp_word_o, last_resp;
   logic [31:0] bus_rdata_i, xfer_data_o, v, ea, ea2;
   cpif_xfer_t  xfer_i;
   cpif_bus_t   alt_i, bus_o;
   cpif_bus_t   log_q [$];
   logic [2:0]  sel;
   logic [3:0]  idx;
   logic [4:0]  cirs [4];
   integer      seed;
   int          miscompares, checked, n_resp, n_unimpl, n_linef, n_done;

   cpif_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
      .op_word_i(op_word_i), .cmd_word_i(cmd_word_i), .resp_req_i(resp_req_i),
      .xfer_valid_i(xfer_valid_i), .xfer_i(xfer_i), .alt_valid_i(alt_valid_i),
      .alt_i(alt_i), .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i),
      .bus_req_o(bus_req_o), .bus_o(bus_o), .busy_o(busy_o),
      .resp_valid_o(resp_valid_o), .resp_word_o(resp_word_o),
      .unimpl_o(unimpl_o), .linef_o(linef_o), .xfer_done_o(xfer_done_o),
      .xfer_data_o(xfer_data_o));

   cpif_cop_model i_cop (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(bus_req_o),
      .bus_i(bus_o), .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i));

   always #12.5 clk_i = ~clk_i;

   // ==========================================================
   // monitor: log each new strobe, count the pulses
   always @(posedge clk_i) begin
      req_q <= bus_req_o;
      if (bus_req_o === 1'b1 && req_q !== 1'b1) log_q.push_back(bus_o);
      if (resp_valid_o === 1'b1) begin
         n_resp++;
         last_resp = resp_word_o;
      end
      n_unimpl += (unimpl_o === 1'b1);
      n_linef  += (linef_o === 1'b1);
      n_done   += (xfer_done_o === 1'b1);
   end

   function automatic logic [31:0] cop_addr(input logic [2:0] s,
                                            input logic [4:0] ofs);
      return {12'h0, CPU_TYPE_COPROC, s, 8'h0, ofs};
   endfunction : cop_addr

   function automatic logic [15:0] exp_resp(input logic [2:0] s);
      return 16'h8000 | {13'h0, s};
   endfunction : exp_resp

   task automatic give_verdict;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_cyc(input int k, input logic [2:0] fc,
                          input logic [31:0] addr, input logic rd);
      cpif_bus_t d;
      d = (k < log_q.size()) ? log_q[k] : '1;
      chk({29'h0, d.fc}, {29'h0, fc});
      chk(d.addr, addr);
      chk({31'h0, d.rd}, {31'h0, rd});
   endtask : chk_cyc

   // one request pulse, then a bounded wait for idle
   task automatic fire(input int kind);
      int k;
      log_q.delete();
      {n_resp, n_unimpl, n_linef, n_done} = '0;
      @(posedge clk_i);
      op_valid_i   <= (kind == 0);
      resp_req_i   <= (kind == 1);
      xfer_valid_i <= (kind == 2);
      alt_valid_i  <= (kind == 3);
      @(posedge clk_i);
      {op_valid_i, resp_req_i, xfer_valid_i, alt_valid_i} <= 4'h0;
      k = 0;
      #1;
      while (busy_o !== 1'b0 && k < 400) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k >= 400) chk(32'h0, 32'h1);
      repeat (3) @(posedge clk_i);
      #1;
   endtask : fire

   // watchdog at 20000 cycles, well past the expected several hundred cycles
   initial begin
      #(25 * 20000);
      miscompares++;
      give_verdict();
   end

   initial begin
      {clk_i, op_valid_i, resp_req_i, xfer_valid_i, alt_valid_i} = '0;
      rst_i = 1'b1;
      {op_word_i, cmd_word_i} = '0;
      xfer_i = '0;
      alt_i = BUS_IDLE;
      seed = 32'h3e48;
      cirs = '{OFS_OPERAND, OFS_INSTR_PTR, OFS_OPND_PTR, 5'h0c};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // selector zero: every type, no bus cycle at all
      for (int t = 0; t < 8; t++) begin
         op_word_i <= {LINEF_CODE, SEL_NONE, 3'(t), 6'($random(seed))};
         fire(0);
         chk(n_unimpl, (t != 0));
         chk(n_linef, (t == 0));
         chk(log_q.size(), 0);
      end
      // words outside line f are ignored
      for (int t = 0; t < 4; t++) begin
         op_word_i <= {4'(t * 4 + 2), 12'($random(seed))};
         fire(0);
         chk(n_unimpl + n_linef + n_resp + log_q.size(), 0);
      end
      // coprocessor instructions, edge selectors first
      for (int i = 0; i < 8; i++) begin
         sel = (i == 0) ? 3'h7 : (i == 1) ? 3'h1 :
               3'h1 + 3'($unsigned($random(seed)) % 7);
         cmd_word_i <= 16'($random(seed));
         op_word_i  <= {LINEF_CODE, sel, 9'($random(seed))};
         fire(0);
         chk(log_q.size(), 2);
         chk_cyc(0, FC_CPU_SPACE, cop_addr(sel, OFS_COMMAND), 1'b0);
         chk({16'h0, log_q[0].wdata[15:0]}, {16'h0, cmd_word_i});
         chk_cyc(1, FC_CPU_SPACE, cop_addr(sel, OFS_RESPONSE), 1'b1);
         chk(n_resp, 1);
         chk({16'h0, last_resp}, {16'h0, exp_resp(sel)});
      end
      fire(1);
      chk_cyc(0, FC_CPU_SPACE, cop_addr(sel, OFS_RESPONSE), 1'b1);
      chk({16'h0, last_resp}, {16'h0, exp_resp(sel)});
      // operands both ways, reserved place last
      for (int c = 0; c < 4; c++) begin
         idx = 4'($random(seed));
         ea  = {26'h0, idx, 2'h0};
         ea2 = {26'h0, idx + 4'h1, 2'h0};
         v   = i_cop.mem_r[idx];
         xfer_i <= '{ea: ea, space: 3'h1, to_cop: 1'b1, interface_register: cirs[c]};
         fire(2);
         chk_cyc(0, 3'h1, ea, 1'b1);
         chk_cyc(1, FC_CPU_SPACE, cop_addr(sel, cirs[c]), 1'b0);
         chk(log_q[1].wdata, v);
         xfer_i <= '{ea: ea2, space: 3'h2, to_cop: 1'b0, interface_register: cirs[c]};
         fire(2);
         v = (c == 3) ? 32'h0 : v;
         chk_cyc(0, FC_CPU_SPACE, cop_addr(sel, cirs[c]), 1'b1);
         chk_cyc(1, 3'h2, ea2, 1'b0);
         chk(xfer_data_o, v);
         chk(i_cop.mem_r[idx + 4'h1], v);
         chk(n_done, 1);
      end
      // mid-run reset: outputs cleared, selector forgotten
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({28'h0, busy_o, bus_req_o, resp_valid_o, xfer_done_o}, 32'h0);
      chk({16'h0, resp_word_o}, 32'h0);
      fire(1);
      chk(n_resp + log_q.size(), 0);
      // alternate space move may use selector zero
      alt_i <= '{addr: cop_addr(SEL_NONE, OFS_RESPONSE), fc: FC_CPU_SPACE,
                 rd: 1'b1, word: 1'b1, wdata: 32'h0};
      fire(3);
      chk_cyc(0, FC_CPU_SPACE, cop_addr(SEL_NONE, OFS_RESPONSE), 1'b1);
      chk(xfer_data_o, {16'h0, exp_resp(SEL_NONE)});
      give_verdict();
   end

endmodule : tb_coprocessor_interface_addressing

`default_nettype wire
